// ---- hdl/fgc_pkg.sv ----
// package: register map, field layout, reset values and timing for the fan and io config bank
package fgc_pkg;
  // clock and tach measurement timebase
  localparam int CLK_HZ = 100_000_000;
  localparam int TACH_BASE_HZ = 22_500;
  localparam int TACH_BASE_CYCLES = CLK_HZ / TACH_BASE_HZ;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONFIG_ONE = 6'h00;
  localparam logic [5:0] IDX_TACH_PRESCALE_UPPER = 6'h03;
  localparam logic [5:0] IDX_FAN_DAC_LEVEL = 6'h04;
  localparam logic [5:0] IDX_FAN_PULSE_DUTY = 6'h05;
  localparam logic [5:0] IDX_FACTORY_STORE_ONE = 6'h06;
  localparam logic [5:0] IDX_MISC_CONFIG_THREE = 6'h07;
  localparam logic [5:0] IDX_IO_LINES_0_3 = 6'h08;
  localparam logic [5:0] IDX_IO_LINES_4_7 = 6'h09;
  localparam logic [5:0] IDX_IO_LINES_8_11 = 6'h0a;
  localparam logic [5:0] IDX_IO_STATUS = 6'h20;
  localparam logic [5:0] IDX_IO_DRIVE = 6'h21;

  // reset values
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  localparam logic [7:0] RST_TACH_PRESCALE = 8'h55;
  localparam logic [7:0] RST_DAC_LEVEL = 8'hff;
  localparam logic [7:0] RST_PULSE_DUTY = 8'hff;
  localparam logic [7:0] RST_FACTORY = 8'h00;
  localparam logic [7:0] RST_MISC_THREE = 8'h00;
  localparam logic [7:0] RST_IO_CONFIG = 8'h00;
  localparam logic [12:0] RST_IO_DRIVE = 13'h0000;

  // field positions
  localparam int CFG1_DAC_AUTO_BIT = 5;
  localparam int CFG1_PWM_AUTO_BIT = 6;
  localparam int CFG1_SOFT_RESET_BIT = 7;
  localparam int MISC_IO16_SELECT_BIT = 0;
  localparam int MISC_INTRUSION_CLEAR_BIT = 1;
  localparam int MISC_REF_SELECT_BIT = 2;
  localparam int MISC_IO16_DIR_BIT = 6;
  localparam int MISC_IO16_POL_BIT = 7;
  localparam logic [7:0] MISC_WRITABLE_MASK = 8'hc7;
  localparam logic [7:0] DUTY_WRITABLE_MASK = 8'hf0;
  localparam int DUTY_LSB = 4;
  localparam int DAC_MIN_LSB = 4;

  // io lines: 0..11 plus line 16 in slot 12
  localparam int IO_LINES = 13;
  localparam int IO_LINE16_SLOT = 12;
  localparam int IO_CFG_REGS = 3;
  localparam int TACH_CHANNELS = 4;

  // pwm period runs steps 0..14, fifteen steps per period
  localparam logic [3:0] PWM_LAST_STEP = 4'he;

  // avalon-mm request, byte addressed
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } fgc_av_req_t;
endpackage

// ---- hdl/fgc_fan_io_regs.sv ----
// fan prescaler, dac, pwm and general io configuration bank with avalon-mm slave
`timescale 1ns/1ps
module fgc_fan_io_regs #(
  parameter int TACH_BASE_CYCLES = fgc_pkg::TACH_BASE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input fgc_pkg::fgc_av_req_t avReq,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  // automatic fan control requests from temperature logic
  input wire logic [7:0] autoDacLevel,
  input wire logic [3:0] autoPwmCode,
  input wire logic overtempAlarm,
  // fan outputs
  output logic [3:0] tachTick,
  output logic [7:0] dacLevel,
  output logic pwmOut,
  // misc controls
  output logic refSelect,
  output logic intrusionLatchClear,
  // io pins, slot 12 is the alarm pin unless switched to io
  input wire logic [12:0] ioIn,
  output logic [12:0] ioOut,
  output logic [12:0] ioOe
);

  // apply a line's polarity: active low lines are inverted
  function automatic logic applyPolarity(input logic level, input logic activeHigh);
    applyPolarity = activeHigh ? level : ~level;
  endfunction

  // byte address match for a register index
  function automatic logic regHit(input logic [7:0] addr, input logic [5:0] idx);
    regHit = (addr == {idx, 2'b00});
  endfunction

  // divide-by-2^code mask for the shared divider counter
  function automatic logic [2:0] divMask(input logic [1:0] code);
    case (code)
      2'b00: divMask = 3'h0;
      2'b01: divMask = 3'h1;
      2'b10: divMask = 3'h3;
      default: divMask = 3'h7;
    endcase
  endfunction

  // declared ahead of the storage array whose depth it sets
  localparam int IO_CFG_REGS = fgc_pkg::IO_CFG_REGS;
  logic [7:0] configOne_r;
  logic [7:0] tachPrescale_r;
  logic [7:0] dacLevelReg_r;
  logic [7:0] pulseDuty_r;
  logic [7:0] factoryStore_r;
  logic [7:0] miscThree_r;
  logic [7:0] ioCfg_r [IO_CFG_REGS];
  logic [12:0] ioDrive_r;
  logic [12:0] ioDir;
  logic [12:0] ioPol;
  logic [12:0] ioAsserted_r;
  logic busWrite;
  logic softReset;
  logic regClear;
  logic [15:0] baseCnt_r;
  logic baseTick;
  logic [2:0] divCnt_r;
  logic [3:0] pwmStep_r;
  logic [3:0] dacMin;
  logic [3:0] pwmCode;
  logic [7:0] dacNxt;
  logic [31:0] readNxt;

  // a write commits only at the edge where waitrequest is seen low
  assign busWrite = avReq.write && !avWaitRequest && avReq.byteenable[0];
  assign softReset = busWrite && regHit(avReq.address, fgc_pkg::IDX_CONFIG_ONE)
    && avReq.writedata[fgc_pkg::CFG1_SOFT_RESET_BIT];
  assign regClear = srst || softReset;

  // bus handshake: one wait cycle, then the answer cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      avWaitRequest <= 1'b1;
    end else if ((avReq.read || avReq.write) && avWaitRequest) begin
      avWaitRequest <= 1'b0;
    end else begin
      avWaitRequest <= 1'b1;
    end
  end

  // config one: auto enables; soft reset bit never stays set
  always_ff @(posedge clk) begin
    if (regClear) begin
      configOne_r <= fgc_pkg::RST_CONFIG_ONE;
    end else if (busWrite && regHit(avReq.address, fgc_pkg::IDX_CONFIG_ONE)) begin
      configOne_r <= avReq.writedata[7:0];
    end
  end

  // tach prescaler register, four two-bit fields
  always_ff @(posedge clk) begin
    if (regClear) begin
      tachPrescale_r <= fgc_pkg::RST_TACH_PRESCALE;
    end else if (busWrite && regHit(avReq.address, fgc_pkg::IDX_TACH_PRESCALE_UPPER)) begin
      tachPrescale_r <= avReq.writedata[7:0];
    end
  end

  // dac level register
  always_ff @(posedge clk) begin
    if (regClear) begin
      dacLevelReg_r <= fgc_pkg::RST_DAC_LEVEL;
    end else if (busWrite && regHit(avReq.address, fgc_pkg::IDX_FAN_DAC_LEVEL)) begin
      dacLevelReg_r <= avReq.writedata[7:0];
    end
  end

  // pwm duty register; low nibble is not stored and reads zero
  always_ff @(posedge clk) begin
    if (regClear) begin
      pulseDuty_r <= fgc_pkg::RST_PULSE_DUTY & fgc_pkg::DUTY_WRITABLE_MASK;
    end else if (busWrite && regHit(avReq.address, fgc_pkg::IDX_FAN_PULSE_DUTY)) begin
      pulseDuty_r <= avReq.writedata[7:0] & fgc_pkg::DUTY_WRITABLE_MASK;
    end
  end

  // factory store: plain storage, software is expected to leave it alone
  always_ff @(posedge clk) begin
    if (regClear) begin
      factoryStore_r <= fgc_pkg::RST_FACTORY;
    end else if (busWrite && regHit(avReq.address, fgc_pkg::IDX_FACTORY_STORE_ONE)) begin
      factoryStore_r <= avReq.writedata[7:0];
    end
  end

  // misc config three; bits 5-3 are never stored
  always_ff @(posedge clk) begin
    if (regClear) begin
      miscThree_r <= fgc_pkg::RST_MISC_THREE;
    end else if (busWrite && regHit(avReq.address, fgc_pkg::IDX_MISC_CONFIG_THREE)) begin
      miscThree_r <= avReq.writedata[7:0] & fgc_pkg::MISC_WRITABLE_MASK;
    end
  end

  // io config registers 0x08..0x0a, one per group of four lines
  generate
    for (genvar g = 0; g < IO_CFG_REGS; g++) begin : gIoCfg
      always_ff @(posedge clk) begin
        if (regClear) begin
          ioCfg_r[g] <= fgc_pkg::RST_IO_CONFIG;
        end else if (busWrite
            && regHit(avReq.address, fgc_pkg::IDX_IO_LINES_0_3 + 6'(g))) begin
          ioCfg_r[g] <= avReq.writedata[7:0];
        end
      end
    end
  endgenerate

  // io drive register: asserted state software wants on output lines
  always_ff @(posedge clk) begin
    if (regClear) begin
      ioDrive_r <= fgc_pkg::RST_IO_DRIVE;
    end else if (busWrite && regHit(avReq.address, fgc_pkg::IDX_IO_DRIVE)) begin
      ioDrive_r <= avReq.writedata[12:0];
    end
  end

  // unpack direction and polarity per line
  generate
    for (genvar n = 0; n < 12; n++) begin : gIoUnpack
      assign ioDir[n] = ioCfg_r[n / 4][2 * (n % 4)];
      assign ioPol[n] = ioCfg_r[n / 4][2 * (n % 4) + 1];
    end
  endgenerate
  assign ioDir[fgc_pkg::IO_LINE16_SLOT] = miscThree_r[fgc_pkg::MISC_IO16_DIR_BIT];
  assign ioPol[fgc_pkg::IO_LINE16_SLOT] = miscThree_r[fgc_pkg::MISC_IO16_POL_BIT];

  // io pin drive; slot 12 is the alarm output unless switched to io
  generate
    for (genvar n = 0; n < fgc_pkg::IO_LINES; n++) begin : gIoPin
      always_ff @(posedge clk) begin
        if (srst) begin
          ioOut[n] <= 1'b0;
          ioOe[n] <= 1'b0;
          ioAsserted_r[n] <= 1'b0;
        end else if (n == fgc_pkg::IO_LINE16_SLOT
            && !miscThree_r[fgc_pkg::MISC_IO16_SELECT_BIT]) begin
          ioOut[n] <= 1'b0; // alarm pulls low, open drain
          ioOe[n] <= overtempAlarm;
          ioAsserted_r[n] <= 1'b0;
        end else begin
          ioOut[n] <= applyPolarity(ioDrive_r[n], ioPol[n]);
          ioOe[n] <= ioDir[n];
          ioAsserted_r[n] <= applyPolarity(ioIn[n], ioPol[n]);
        end
      end
    end
  endgenerate

  // read mux, sampled in the wait cycle so data stand with waitrequest low
  always_comb begin
    readNxt = 32'h0000_0000;
    case (avReq.address)
      {fgc_pkg::IDX_CONFIG_ONE, 2'b00}: readNxt[7:0] = configOne_r;
      {fgc_pkg::IDX_TACH_PRESCALE_UPPER, 2'b00}: readNxt[7:0] = tachPrescale_r;
      {fgc_pkg::IDX_FAN_DAC_LEVEL, 2'b00}: readNxt[7:0] = dacLevelReg_r;
      {fgc_pkg::IDX_FAN_PULSE_DUTY, 2'b00}: readNxt[7:0] = pulseDuty_r;
      {fgc_pkg::IDX_FACTORY_STORE_ONE, 2'b00}: readNxt[7:0] = factoryStore_r;
      {fgc_pkg::IDX_MISC_CONFIG_THREE, 2'b00}: readNxt[7:0] = miscThree_r;
      {fgc_pkg::IDX_IO_LINES_0_3, 2'b00}: readNxt[7:0] = ioCfg_r[0];
      {fgc_pkg::IDX_IO_LINES_4_7, 2'b00}: readNxt[7:0] = ioCfg_r[1];
      {fgc_pkg::IDX_IO_LINES_8_11, 2'b00}: readNxt[7:0] = ioCfg_r[2];
      {fgc_pkg::IDX_IO_STATUS, 2'b00}: readNxt[12:0] = ioAsserted_r;
      {fgc_pkg::IDX_IO_DRIVE, 2'b00}: readNxt[12:0] = ioDrive_r;
      default: readNxt = 32'h0000_0000; // unmapped reads return zero
    endcase
  end

  // read data register
  always_ff @(posedge clk) begin
    if (srst) begin
      avReadData <= 32'h0000_0000;
    end else if (avReq.read && avWaitRequest) begin
      avReadData <= readNxt;
    end
  end

  // tach timebase: one tick per 22.5 kHz period
  assign baseTick = (baseCnt_r == 16'(TACH_BASE_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (srst) begin
      baseCnt_r <= 16'h0000;
    end else if (baseTick) begin
      baseCnt_r <= 16'h0000;
    end else begin
      baseCnt_r <= baseCnt_r + 16'h0001;
    end
  end

  // shared divider count; channels pick 1 of 1,2,4 or 8 base ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      divCnt_r <= 3'h0;
    end else if (baseTick) begin
      divCnt_r <= divCnt_r + 3'h1;
    end
  end

  // per-channel measurement tick pulses
  generate
    for (genvar c = 0; c < fgc_pkg::TACH_CHANNELS; c++) begin : gTach
      always_ff @(posedge clk) begin
        if (srst) begin
          tachTick[c] <= 1'b0;
        end else begin
          tachTick[c] <= baseTick
            && ((divCnt_r & divMask(tachPrescale_r[2 * c +: 2])) == 3'h0);
        end
      end
    end
  endgenerate

  // dac: direct in normal mode, floor of upper nibble in automatic mode
  assign dacMin = dacLevelReg_r[fgc_pkg::DAC_MIN_LSB +: 4];
  always_comb begin
    if (!configOne_r[fgc_pkg::CFG1_DAC_AUTO_BIT]) begin
      dacNxt = dacLevelReg_r;
    end else if (autoDacLevel < {dacMin, 4'h0}) begin
      dacNxt = {dacMin, 4'h0};
    end else begin
      dacNxt = autoDacLevel;
    end
  end

  // dac output register
  always_ff @(posedge clk) begin
    if (srst) begin
      dacLevel <= fgc_pkg::RST_DAC_LEVEL;
    end else begin
      dacLevel <= dacNxt;
    end
  end

  // pwm code: register value, or automatic request held above the floor
  always_comb begin
    pwmCode = pulseDuty_r[fgc_pkg::DUTY_LSB +: 4];
    if (configOne_r[fgc_pkg::CFG1_PWM_AUTO_BIT] && autoPwmCode > pwmCode) begin
      pwmCode = autoPwmCode;
    end
  end

  // fifteen-step period: code n is high for n of 15 steps, so 15 is always on
  always_ff @(posedge clk) begin
    if (srst) begin
      pwmStep_r <= 4'h0;
    end else if (pwmStep_r == fgc_pkg::PWM_LAST_STEP) begin
      pwmStep_r <= 4'h0;
    end else begin
      pwmStep_r <= pwmStep_r + 4'h1;
    end
  end

  // pwm output register
  always_ff @(posedge clk) begin
    if (srst) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (pwmStep_r < pwmCode);
    end
  end

  // misc level outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      refSelect <= 1'b0;
      intrusionLatchClear <= 1'b0;
    end else begin
      refSelect <= miscThree_r[fgc_pkg::MISC_REF_SELECT_BIT];
      intrusionLatchClear <= miscThree_r[fgc_pkg::MISC_INTRUSION_CLEAR_BIT];
    end
  end

endmodule

// ---- bench/fgc_fan_io_regs_chk.sv ----
// assertion checker for the fan and io config bank
`timescale 1ns/1ps
module fgc_fan_io_regs_chk #(
  parameter int TACH_BASE_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bus
  input wire fgc_pkg::fgc_av_req_t avReq,
  input wire logic [31:0] avReadData,
  input wire logic avWaitRequest,
  // outputs and their causes
  input wire logic [7:0] autoDacLevel,
  input wire logic [3:0] tachTick,
  input wire logic [7:0] dacLevel,
  input wire logic refSelect,
  input wire logic intrusionLatchClear,
  input wire logic [12:0] ioOe
);
  logic [2:0] wrHist_r;
  logic [7:0] autoD1_r;
  logic [7:0] autoD2_r;
  logic wrNear;
  // committed writes of the last three edges; outputs lag the register
  always_ff @(posedge clk) begin
    wrHist_r <= {wrHist_r[1:0], avReq.write & ~avWaitRequest};
  end
  // auto level history, the dac may move only after it
  always_ff @(posedge clk) begin
    autoD1_r <= autoDacLevel;
    autoD2_r <= autoD1_r;
  end
  assign wrNear = |wrHist_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_WAIT_ONE: assert property ((avReq.read | avReq.write) && avWaitRequest |=> !avWaitRequest)
    else $error("no answer after one wait cycle");
  AST_WAIT_PULSE: assert property (!avWaitRequest |=> avWaitRequest) else $error("wait low too long");
  AST_WAIT_CAUSE: assert property (!avWaitRequest |-> $past(avReq.read | avReq.write))
    else $error("answer without request");
  AST_READ_HIGH: assert property (avReadData[31:13] == 19'h00000) else $error("upper read bits set");
  AST_TACH_GAP: assert property (tachTick != 4'h0 |=> tachTick == 4'h0) else $error("tach pulse too long");
  AST_CLEAR_CAUSE: assert property ($changed(intrusionLatchClear) |-> wrNear) else $error("clear moved");
  AST_REF_CAUSE: assert property ($changed(refSelect) |-> wrNear) else $error("ref moved");
  AST_DAC_CAUSE: assert property ($changed(dacLevel) |-> wrNear || autoD1_r != autoD2_r)
    else $error("dac moved");
  AST_OE_CAUSE: assert property ($changed(ioOe[11:0]) |-> wrNear) else $error("io enable moved");
  AST_RESET_OUT: assert property ($fell(srst) |-> avWaitRequest && dacLevel == 8'hff && ioOe == 13'h0000)
    else $error("bad reset outputs");
  // main scenarios
  cover property (avReq.write && !avWaitRequest);
  cover property (avReq.read && !avWaitRequest);
  cover property (tachTick[3]);
endmodule

// ---- bench/fgc_fan_io_regs_tb.sv ----
// self-checking bench for the fan and io config bank
`timescale 1ns/1ps
module fgc_fan_io_regs_tb;
  localparam int BASE = 8;
  // design ports
  logic clk = 1'b0;
  logic srst = 1'b1;
  fgc_pkg::fgc_av_req_t avReq = '0;
  logic [7:0] autoDacLevel = 8'h00;
  logic [3:0] autoPwmCode = 4'h0;
  logic overtempAlarm = 1'b0;
  logic [12:0] ioIn = 13'h0000;
  logic [31:0] avReadData;
  logic avWaitRequest, pwmOut, refSelect, intrusionLatchClear;
  logic [3:0] tachTick;
  logic [7:0] dacLevel;
  logic [12:0] ioOut, ioOe;
  // bench state
  int n_fail = 0;
  int total_checks = 0;
  int seed = 58;
  int cyc = 0;
  int cnt [0:3];
  logic [3:0] be = 4'hf;
  logic [3:0] a4;
  logic [31:0] rd;
  logic [12:0] dir, pol, drv;
  logic [7:0] mdl [0:10];
  logic [7:0] rstV [0:10] = '{8'h00, 8'h00, 8'h00, 8'h55, 8'hff, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [0:10] = '{8'h7f, 8'h00, 8'h00, 8'hff, 8'hff, 8'hf0, 8'hff, 8'hc7, 8'hff, 8'hff, 8'hff};
  logic [3:0] codes [0:6] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'he, 4'hf};

  fgc_fan_io_regs #(.TACH_BASE_CYCLES(BASE)) i_fgc_fan_io_regs (.clk(clk), .srst(srst), .avReq(avReq),
    .avReadData(avReadData), .avWaitRequest(avWaitRequest), .autoDacLevel(autoDacLevel),
    .autoPwmCode(autoPwmCode), .overtempAlarm(overtempAlarm), .tachTick(tachTick), .dacLevel(dacLevel),
    .pwmOut(pwmOut), .refSelect(refSelect), .intrusionLatchClear(intrusionLatchClear), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe));

  // 100 MHz clock
  always #5 clk = ~clk;
  // hang guard, a stuck handshake ends as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", name, exp, got);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(logic w, logic [5:0] idx, logic [12:0] d);
    @(posedge clk);
    avReq.read <= ~w;
    avReq.write <= w;
    avReq.address <= {idx, 2'b00};
    avReq.writedata <= {19'h00000, d};
    avReq.byteenable <= be;
    @(posedge clk);
    while (avWaitRequest !== 1'b0) @(posedge clk);
    rd = avReadData;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
  endtask

  task automatic rc(string name, logic [5:0] idx, logic [12:0] e);
    bus(1'b0, idx, 13'h0000);
    chk(name, {19'h00000, e}, rd);
  endtask

  task automatic rst_chk();
    for (int i = 0; i < 11; i++) rc("reset", 6'(i), 13'(rstV[i]));
    rc("unmapped", 6'h3f, 13'h0000);
  endtask

  // count high steps over one fifteen-step period
  task automatic duty(logic [3:0] code);
    int h;
    h = 0;
    repeat (4) @(posedge clk);
    repeat (15) begin
      @(posedge clk);
      h += (pwmOut === 1'b1);
    end
    chk("duty", 32'(code), 32'(h));
  endtask

  function automatic logic [7:0] mx(logic [7:0] a, logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rst_chk();
    // random data through the writable registers 0x03..0x0a, factory store never written
    for (int i = 3; i <= 10; i++) begin
      if (i != 6) begin
        mdl[i] = 8'($random(seed));
        bus(1'b1, 6'(i), 13'(mdl[i]));
        rc("rw", 6'(i), 13'(mdl[i] & msk[i]));
      end
    end
    // refused writes: unmapped place, lane zero disabled
    bus(1'b1, 6'h02, 13'h00ff);
    rc("unmapped", 6'h02, 13'h0000);
    be = 4'he;
    bus(1'b1, 6'h08, 13'h00ff);
    be = 4'hf;
    rc("lane", 6'h08, 13'(mdl[8]));
    @(negedge clk);
    chk("dac", 32'(mdl[4]), 32'(dacLevel));
    // automatic dac with the register nibble as floor
    bus(1'b1, 6'h00, 13'h0020);
    repeat (6) begin
      @(posedge clk);
      autoDacLevel <= 8'($random(seed));
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("dacauto", 32'(mx(autoDacLevel, {mdl[4][7:4], 4'h0})), 32'(dacLevel));
    end
    bus(1'b1, 6'h00, 13'h0000);
    foreach (codes[i]) begin
      bus(1'b1, 6'h05, {5'h00, codes[i], 4'h0});
      duty(codes[i]);
    end
    bus(1'b1, 6'h00, 13'h0040);
    bus(1'b1, 6'h05, 13'h0050);
    repeat (4) begin
      a4 = 4'($random(seed));
      autoPwmCode <= a4;
      duty((a4 > 4'h5) ? a4 : 4'h5);
    end
    // one divisor code per channel
    bus(1'b1, 6'h03, 13'h00e4);
    repeat (4) @(posedge clk);
    cnt = '{0, 0, 0, 0};
    repeat (64 * BASE) begin
      @(posedge clk);
      for (int k = 0; k < 4; k++) cnt[k] += (tachTick[k] === 1'b1);
    end
    for (int k = 0; k < 4; k++) chk("tach", 32'(64 >> k), 32'(cnt[k]));
    // random io direction, polarity and pin levels
    repeat (4) begin
      for (int i = 8; i <= 10; i++) begin
        mdl[i] = 8'($random(seed));
        bus(1'b1, 6'(i), 13'(mdl[i]));
      end
      mdl[7] = (8'($random(seed)) & 8'hc7) | 8'h01;
      bus(1'b1, 6'h07, 13'(mdl[7]));
      drv = 13'($random(seed));
      bus(1'b1, 6'h21, drv);
      ioIn <= 13'($random(seed));
      for (int j = 0; j < 12; j++) begin
        dir[j] = mdl[8 + j / 4][2 * (j % 4)];
        pol[j] = mdl[8 + j / 4][2 * (j % 4) + 1];
      end
      dir[12] = mdl[7][6];
      pol[12] = mdl[7][7];
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("oe", 32'(dir), 32'(ioOe));
      chk("out", 32'(dir & ~(pol ^ drv)), 32'(dir & ioOut));
      chk("ref", 32'(mdl[7][2]), 32'(refSelect));
      chk("clear", 32'(mdl[7][1]), 32'(intrusionLatchClear));
      rc("status", 6'h20, ~(pol ^ ioIn));
    end
    // alarm function of the shared pin, open drain
    bus(1'b1, 6'h07, 13'h0000);
    overtempAlarm <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("alarmoe", 32'h00000001, 32'(ioOe[12]));
    chk("alarmout", 32'h00000000, 32'(ioOut[12]));
    chk("clear", 32'h00000000, 32'(intrusionLatchClear));
    bus(1'b1, 6'h00, 13'h0080);
    rst_chk();
    chk("dacsoft", 32'h000000ff, 32'(dacLevel));
    stop_test();
  end
endmodule

bind fgc_fan_io_regs fgc_fan_io_regs_chk #(.TACH_BASE_CYCLES(TACH_BASE_CYCLES)) i_fgc_fan_io_regs_chk (.clk(clk),
  .srst(srst), .avReq(avReq), .avReadData(avReadData), .avWaitRequest(avWaitRequest), .autoDacLevel(autoDacLevel),
  .tachTick(tachTick), .dacLevel(dacLevel), .refSelect(refSelect), .intrusionLatchClear(intrusionLatchClear),
  .ioOe(ioOe));
